// ---- common/dual_synth_pkg.sv ----
// Shared constants and types for the dual synthesizer mode and control block.
package dual_synth_pkg;
  // Serial word layout: 20 data bits above two target bits.
  localparam int WORD_BITS = 22;
  localparam int DATA_BITS = 20;
  localparam int REF_RATIO_BITS = 15;
  localparam int SWALLOW_BITS = 7;
  localparam int IF_SWALLOW_BITS = 4;
  localparam int PROG_BITS = 11;
  localparam int MOD_BITS = 8;
  // Field positions inside the 20 data bits of a reference word.
  localparam int REF_RATIO_LSB = 0;
  localparam int POLARITY_POS = 15;
  localparam int CURRENT_POS = 16;
  localparam int PUMP_HIZ_POS = 17;
  localparam int LOCK_SEL_POS = 18;
  localparam int MONITOR_SEL_POS = 19;
  // Field positions inside the 20 data bits of a divider word.
  localparam int SWALLOW_LSB = 0;
  localparam int PROG_LSB = 7;
  localparam int MODULUS_POS = 18;
  localparam int SLEEP_POS = 19;
  // Loop indices and the IF prescaler moduli.
  localparam int LOOP_IF = 0;
  localparam int LOOP_RF = 1;
  localparam logic [7:0] IF_SMALL_MOD = 8'h08;
  localparam logic [7:0] IF_LARGE_MOD = 8'h10;
  // Register byte offsets on the bus.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IF_REF_OFFSET = 8'h08;
  localparam logic [7:0] RF_REF_OFFSET = 8'h0c;
  localparam logic [7:0] IF_DIV_OFFSET = 8'h10;
  localparam logic [7:0] RF_DIV_OFFSET = 8'h14;
  // Control register: lock width threshold and lock run length.
  localparam int CTRL_THRESH_LSB = 0;
  localparam int CTRL_RUN_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0402;
  // Status register layout.
  localparam int STAT_LOCKED_LSB = 0;
  localparam int STAT_IF_SLEEP_LSB = 2;
  localparam int STAT_RF_SLEEP_LSB = 4;
  localparam int STAT_OSC_POS = 6;
  localparam int STAT_MF_POS = 7;
  localparam int STAT_RESET_LSB = 8;
  // Register selector codes.
  typedef enum logic [2:0] {
    SEL_CTRL = 3'h0, SEL_STATUS = 3'h1, SEL_IF_REF = 3'h2,
    SEL_RF_REF = 3'h3, SEL_IF_DIV = 3'h4, SEL_RF_DIV = 3'h5,
    SEL_NONE = 3'h7
  } reg_sel_e;
  // Per-loop power state, Gray coded along active, waiting, asleep.
  typedef enum logic [1:0] {
    SLEEP_ACTIVE = 2'b00, SLEEP_WAIT = 2'b01, SLEEP_DOWN = 2'b11
  } sleep_state_e;
endpackage

// ---- logic/dual_synth_mode_control.sv ----
// Mode, divider and powerdown control of a dual IF and RF synthesizer.
`timescale 1ns/1ps
module dual_synth_mode_control
  import dual_synth_pkg::*;
#(
  parameter logic [7:0] RfSmallModulus = 8'h40
) (
  input wire logic ref_clk, // Reference oscillator clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic cyc_i, // Bus cycle.
  input wire logic stb_i, // Bus strobe.
  input wire logic we_i, // Bus write enable.
  input wire logic [7:0] adr_i, // Bus byte address.
  input wire logic [3:0] sel_i, // Bus byte enables.
  input wire logic [31:0] dat_i, // Bus write data.
  output logic [31:0] dat_o, // Bus read data.
  output logic ack_o, // Bus acknowledge.
  input wire logic linkClk, // Serial clock from the host.
  input wire logic linkData, // Serial data from the host.
  input wire logic loadStrobe, // Serial load strobe from the host.
  input wire logic [1:0] prescalerInput, // VCO inputs, 0 IF, 1 RF.
  output logic [1:0] pumpUp, // Charge pump source pulse per loop.
  output logic [1:0] pumpDown, // Charge pump sink pulse per loop.
  output logic [1:0] pumpHiz, // Charge pump floating per loop.
  output logic [1:0] pumpCurrentSelect, // High pump current per loop.
  output logic [1:0] inputDebias, // VCO input in high impedance.
  output logic oscEnable, // Reference oscillator enable.
  output logic multifunctionOut, // Multifunction pin level.
  output logic multifunctionOe // Multifunction pin drive enable.
);

  typedef struct packed {
    logic linkClkMeta;
    logic linkClkSync;
    logic linkClkPrev;
    logic linkDataMeta;
    logic linkDataSync;
    logic strobeMeta;
    logic strobeSync;
    logic strobePrev;
    logic [WORD_BITS-1:0] shiftWord;
    logic [1:0][DATA_BITS-1:0] refWord;
    logic [1:0][DATA_BITS-1:0] divWord;
    logic [1:0] inMeta;
    logic [1:0] inSync;
    logic [1:0] inPrev;
    logic [1:0][REF_RATIO_BITS-1:0] refCnt;
    logic [1:0][MOD_BITS-1:0] preCnt;
    logic [1:0][SWALLOW_BITS-1:0] aCnt;
    logic [1:0][PROG_BITS-1:0] bCnt;
    logic [1:0] refPulse;
    logic [1:0] mainPulse;
    logic [1:0] refSeen;
    logic [1:0] mainSeen;
    logic [1:0][7:0] pumpWidth;
    logic [1:0][7:0] lockRun;
    logic [1:0] locked;
    logic [1:0] pumpUp;
    logic [1:0] pumpDown;
    logic [1:0] pumpHiz;
    sleep_state_e [1:0] sleepState;
    logic mfOut;
    logic mfOe;
    logic [15:0] ctrl;
    logic [31:0] rdData;
    logic ack;
  } state_s;

  state_s stateReg;
  state_s stateNext;

  logic clkRise;
  logic strobeRise;
  logic busTake;
  reg_sel_e busSel;
  logic [1:0] counterReset;
  logic [1:0] held;
  logic [1:0] hizNow;
  logic [1:0] lockInd;
  logic [1:0][SWALLOW_BITS-1:0] swallowSet;
  logic [1:0][PROG_BITS-1:0] progSet;
  logic [1:0][REF_RATIO_BITS-1:0] ratioSet;
  logic [1:0][SWALLOW_BITS-1:0] aNext;
  logic [1:0] refLead;
  logic [1:0] mainLead;
  logic monBoth;
  logic ifLock;
  logic rfLock;
  logic ifMon;
  logic rfMon;
  logic monLoop;

  // Maps a byte address to a register selector.
  function automatic reg_sel_e decodeAddr(input logic [7:0] adr);
    case (adr)
      CTRL_OFFSET: decodeAddr = SEL_CTRL;
      STATUS_OFFSET: decodeAddr = SEL_STATUS;
      IF_REF_OFFSET: decodeAddr = SEL_IF_REF;
      RF_REF_OFFSET: decodeAddr = SEL_RF_REF;
      IF_DIV_OFFSET: decodeAddr = SEL_IF_DIV;
      RF_DIV_OFFSET: decodeAddr = SEL_RF_DIV;
      default: decodeAddr = SEL_NONE;
    endcase
  endfunction

  // Prescaler modulus for a loop; one above the base modulus while swallowing.
  function automatic logic [7:0] modulus(input int loop, input logic big,
                                         input logic swallowing);
    logic [7:0] base;
    base = 8'h00;
    if (loop == LOOP_IF) begin
      base = big ? IF_LARGE_MOD : IF_SMALL_MOD;
    end else begin
      base = big ? {RfSmallModulus[6:0], 1'b0} : RfSmallModulus;
    end
    modulus = swallowing ? base + 8'h01 : base;
  endfunction

  always_comb begin
    stateNext = stateReg;
    clkRise = stateReg.linkClkSync & ~stateReg.linkClkPrev;
    strobeRise = stateReg.strobeSync & ~stateReg.strobePrev;
    busTake = cyc_i & stb_i & ~stateReg.ack;
    busSel = decodeAddr(adr_i);
    counterReset = 2'b00;
    held = 2'b00;
    hizNow = 2'b00;
    lockInd = 2'b00;
    swallowSet = '0;
    progSet = '0;
    ratioSet = '0;
    aNext = '0;
    refLead = 2'b00;
    mainLead = 2'b00;
    monBoth = stateReg.refWord[LOOP_IF][MONITOR_SEL_POS] &
              stateReg.refWord[LOOP_RF][MONITOR_SEL_POS];
    ifLock = stateReg.refWord[LOOP_IF][LOCK_SEL_POS];
    rfLock = stateReg.refWord[LOOP_RF][LOCK_SEL_POS];
    ifMon = stateReg.refWord[LOOP_IF][MONITOR_SEL_POS];
    rfMon = stateReg.refWord[LOOP_RF][MONITOR_SEL_POS];
    monLoop = rfMon;

    // Two-stage synchronisers for every pin that crosses into ref_clk.
    stateNext.linkClkMeta = linkClk;
    stateNext.linkClkSync = stateReg.linkClkMeta;
    stateNext.linkClkPrev = stateReg.linkClkSync;
    stateNext.linkDataMeta = linkData;
    stateNext.linkDataSync = stateReg.linkDataMeta;
    stateNext.strobeMeta = loadStrobe;
    stateNext.strobeSync = stateReg.strobeMeta;
    stateNext.strobePrev = stateReg.strobeSync;
    stateNext.inMeta = prescalerInput;
    stateNext.inSync = stateReg.inMeta;
    stateNext.inPrev = stateReg.inSync;

    // The serial path is never gated by any power state.
    if (clkRise) begin
      stateNext.shiftWord = {stateReg.shiftWord[WORD_BITS-2:0],
                             stateReg.linkDataSync};
    end
    if (strobeRise) begin
      if (stateReg.shiftWord[1]) begin
        stateNext.divWord[stateReg.shiftWord[0]] =
          stateReg.shiftWord[WORD_BITS-1:2];
      end else begin
        stateNext.refWord[stateReg.shiftWord[0]] =
          stateReg.shiftWord[WORD_BITS-1:2];
      end
    end

    for (int i = 0; i < 2; i++) begin
      ratioSet[i] = stateReg.refWord[i][REF_RATIO_LSB +: REF_RATIO_BITS];
      progSet[i] = stateReg.divWord[i][PROG_LSB +: PROG_BITS];
      if (i == LOOP_IF) begin
        swallowSet[i] = {3'b000,
          stateReg.divWord[i][SWALLOW_LSB +: IF_SWALLOW_BITS]};
      end else begin
        swallowSet[i] = stateReg.divWord[i][SWALLOW_LSB +: SWALLOW_BITS];
      end
      counterReset[i] = monBoth & stateReg.refWord[i][LOCK_SEL_POS];
      held[i] = counterReset[i] |
                (stateReg.sleepState[i] == SLEEP_DOWN);
      hizNow[i] = stateReg.refWord[i][PUMP_HIZ_POS] | held[i];

      if (held[i]) begin
        // Both counters sit at their load values, so release starts them
        // on the same edge and keeps them aligned.
        stateNext.refCnt[i] = ratioSet[i] - 15'h0001;
        stateNext.preCnt[i] = modulus(i,
          stateReg.divWord[i][MODULUS_POS], swallowSet[i] != '0) - 8'h01;
        stateNext.aCnt[i] = swallowSet[i];
        stateNext.bCnt[i] = progSet[i];
        stateNext.refPulse[i] = 1'b0;
        stateNext.mainPulse[i] = 1'b0;
        stateNext.refSeen[i] = 1'b0;
        stateNext.mainSeen[i] = 1'b0;
        stateNext.pumpWidth[i] = 8'h00;
        stateNext.lockRun[i] = 8'h00;
        stateNext.locked[i] = 1'b0;
      end else begin
        stateNext.refPulse[i] = stateReg.refCnt[i] == '0;
        if (stateReg.refCnt[i] == '0) begin
          stateNext.refCnt[i] = ratioSet[i] - 15'h0001;
        end else begin
          stateNext.refCnt[i] = stateReg.refCnt[i] - 15'h0001;
        end

        // Pulse swallow: A prescaler cycles of P+1, then B-A cycles of P.
        stateNext.mainPulse[i] = 1'b0;
        if (stateReg.inSync[i] & ~stateReg.inPrev[i]) begin
          if (stateReg.preCnt[i] != '0) begin
            stateNext.preCnt[i] = stateReg.preCnt[i] - 8'h01;
          end else if (stateReg.bCnt[i] <= 11'h001) begin
            stateNext.mainPulse[i] = 1'b1;
            stateNext.aCnt[i] = swallowSet[i];
            stateNext.bCnt[i] = progSet[i];
            stateNext.preCnt[i] = modulus(i,
              stateReg.divWord[i][MODULUS_POS], swallowSet[i] != '0) - 8'h01;
          end else begin
            aNext[i] = (stateReg.aCnt[i] != '0) ?
                       stateReg.aCnt[i] - 7'h01 : 7'h00;
            stateNext.aCnt[i] = aNext[i];
            stateNext.bCnt[i] = stateReg.bCnt[i] - 11'h001;
            stateNext.preCnt[i] = modulus(i,
              stateReg.divWord[i][MODULUS_POS], aNext[i] != '0) - 8'h01;
          end
        end

        // Phase frequency detector: the leading edge holds its flag.
        stateNext.refSeen[i] = stateReg.refSeen[i] | stateNext.refPulse[i];
        stateNext.mainSeen[i] = stateReg.mainSeen[i] | stateNext.mainPulse[i];
        if (stateNext.refSeen[i] & stateNext.mainSeen[i]) begin
          stateNext.refSeen[i] = 1'b0;
          stateNext.mainSeen[i] = 1'b0;
        end

        // Lock judged once per comparison cycle from the pump pulse width.
        if (stateNext.refPulse[i]) begin
          stateNext.pumpWidth[i] = 8'h00;
          if (stateReg.pumpWidth[i] <= stateReg.ctrl[CTRL_THRESH_LSB +: 8])
          begin
            if (stateReg.lockRun[i] >= stateReg.ctrl[CTRL_RUN_LSB +: 8]) begin
              stateNext.locked[i] = 1'b1;
            end else begin
              stateNext.lockRun[i] = stateReg.lockRun[i] + 8'h01;
            end
          end else begin
            stateNext.lockRun[i] = 8'h00;
            stateNext.locked[i] = 1'b0;
          end
        end else if ((stateReg.refSeen[i] ^ stateReg.mainSeen[i]) &&
                     stateReg.pumpWidth[i] != 8'hff) begin
          stateNext.pumpWidth[i] = stateReg.pumpWidth[i] + 8'h01;
        end
      end

      refLead[i] = stateNext.refSeen[i] & ~stateNext.mainSeen[i];
      mainLead[i] = stateNext.mainSeen[i] & ~stateNext.refSeen[i];
      if (stateReg.refWord[i][POLARITY_POS]) begin
        stateNext.pumpUp[i] = ~hizNow[i] & refLead[i];
        stateNext.pumpDown[i] = ~hizNow[i] & mainLead[i];
      end else begin
        stateNext.pumpUp[i] = ~hizNow[i] & mainLead[i];
        stateNext.pumpDown[i] = ~hizNow[i] & refLead[i];
      end
      stateNext.pumpHiz[i] = hizNow[i];

      // Power state of the loop.
      case (stateReg.sleepState[i])
        SLEEP_ACTIVE: stateNext.sleepState[i] = SLEEP_ACTIVE;
        SLEEP_WAIT: begin
          if (~stateReg.pumpUp[i] & ~stateReg.pumpDown[i]) begin
            stateNext.sleepState[i] = SLEEP_DOWN;
          end
        end
        SLEEP_DOWN: stateNext.sleepState[i] = SLEEP_DOWN;
        default: stateNext.sleepState[i] = SLEEP_ACTIVE;
      endcase
      if (strobeRise && stateReg.shiftWord[1:0] == {1'b1, i[0]}) begin
        if (!stateReg.shiftWord[2 + SLEEP_POS]) begin
          stateNext.sleepState[i] = SLEEP_ACTIVE;
        end else if (stateReg.refWord[i][PUMP_HIZ_POS]) begin
          stateNext.sleepState[i] = SLEEP_DOWN;
        end else if (stateReg.sleepState[i] != SLEEP_DOWN) begin
          stateNext.sleepState[i] = SLEEP_WAIT;
        end
      end

      lockInd[i] = stateReg.locked[i] & ~stateReg.pumpUp[i] &
                   ~stateReg.pumpDown[i];
    end

    // Multifunction pin selection.
    stateNext.mfOe = 1'b1;
    stateNext.mfOut = 1'b0;
    case ({rfMon, ifMon})
      2'b00: begin
        if (ifLock | rfLock) begin
          stateNext.mfOut = (~ifLock | lockInd[LOOP_IF]) &
                            (~rfLock | lockInd[LOOP_RF]);
        end else begin
          stateNext.mfOut = 1'b0;
        end
      end
      2'b01, 2'b10: begin
        if (ifLock) begin
          stateNext.mfOut = stateNext.mainPulse[monLoop];
        end else begin
          stateNext.mfOut = stateNext.refPulse[monLoop];
        end
      end
      2'b11: begin
        if (~ifLock & ~rfLock) begin
          stateNext.mfOe = stateReg.refWord[LOOP_RF][CURRENT_POS];
        end
      end
      default: stateNext.mfOut = 1'b0;
    endcase

    // Bus slave: one-cycle registered answer, unmapped reads give zero.
    stateNext.ack = busTake;
    if (busTake) begin
      stateNext.rdData = 32'h0000_0000;
      case (busSel)
        SEL_CTRL: stateNext.rdData = {16'h0000, stateReg.ctrl};
        SEL_STATUS: begin
          stateNext.rdData[STAT_LOCKED_LSB +: 2] = stateReg.locked;
          stateNext.rdData[STAT_IF_SLEEP_LSB +: 2] =
            stateReg.sleepState[LOOP_IF];
          stateNext.rdData[STAT_RF_SLEEP_LSB +: 2] =
            stateReg.sleepState[LOOP_RF];
          stateNext.rdData[STAT_OSC_POS] = oscEnable;
          stateNext.rdData[STAT_MF_POS] = stateReg.mfOut;
          stateNext.rdData[STAT_RESET_LSB +: 2] = counterReset;
        end
        SEL_IF_REF: stateNext.rdData = {12'h000, stateReg.refWord[LOOP_IF]};
        SEL_RF_REF: stateNext.rdData = {12'h000, stateReg.refWord[LOOP_RF]};
        SEL_IF_DIV: stateNext.rdData = {12'h000, stateReg.divWord[LOOP_IF]};
        SEL_RF_DIV: stateNext.rdData = {12'h000, stateReg.divWord[LOOP_RF]};
        default: stateNext.rdData = 32'h0000_0000;
      endcase
      if (we_i && busSel == SEL_CTRL) begin
        if (sel_i[0]) begin
          stateNext.ctrl[7:0] = dat_i[7:0];
        end
        if (sel_i[1]) begin
          stateNext.ctrl[15:8] = dat_i[15:8];
        end
      end
    end

    if (reset) begin
      stateNext = '0;
      stateNext.ctrl = CTRL_RESET;
      stateNext.mfOe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    stateReg <= stateNext;
  end

  assign oscEnable = ~(stateReg.divWord[LOOP_IF][SLEEP_POS] &
                       stateReg.divWord[LOOP_RF][SLEEP_POS]);
  assign pumpCurrentSelect = {stateReg.refWord[LOOP_RF][CURRENT_POS],
                              stateReg.refWord[LOOP_IF][CURRENT_POS]};
  assign inputDebias = {stateReg.sleepState[LOOP_RF] == SLEEP_DOWN,
                        stateReg.sleepState[LOOP_IF] == SLEEP_DOWN};
  assign pumpUp = stateReg.pumpUp;
  assign pumpDown = stateReg.pumpDown;
  assign pumpHiz = stateReg.pumpHiz;
  assign multifunctionOut = stateReg.mfOut;
  assign multifunctionOe = stateReg.mfOe;
  assign dat_o = stateReg.rdData;
  assign ack_o = stateReg.ack;

endmodule // dual_synth_mode_control

// ---- tb/serial_host_model.sv ----
// Host side of the three-wire programming link.
`timescale 1ns/1ps
module serial_host_model (
  output logic linkClk, // Serial clock, still between words.
  output logic linkData, // Serial data.
  output logic loadStrobe // Load strobe.
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
    loadStrobe = 1'b0;
  end
  // The first delay keeps the link out of phase with the block clock.
  task automatic send(input logic [21:0] word);
    #137;
    for (int i = 21; i >= 0; i--) begin
      linkData = word[i];
      #400 linkClk = 1'b1;
      #400 linkClk = 1'b0;
    end
    #400 loadStrobe = 1'b1;
    #400 loadStrobe = 1'b0;
    linkData = ~word[0];
  endtask
endmodule // serial_host_model

// ---- tb/dual_synth_mode_control_props.sv ----
// Concurrent checks on the ports of the dual synthesizer control block.
`timescale 1ns/1ps
module dual_synth_mode_control_props (
  input wire logic ref_clk, // Block clock.
  input wire logic reset, // Synchronous reset.
  input wire logic cyc_i, // Bus cycle.
  input wire logic stb_i, // Bus strobe.
  input wire logic ack_o, // Bus acknowledge.
  input wire logic [31:0] dat_o, // Bus read data.
  input wire logic [1:0] pumpUp, // Pump source pulses.
  input wire logic [1:0] pumpDown, // Pump sink pulses.
  input wire logic [1:0] pumpHiz, // Pump floating.
  input wire logic [1:0] inputDebias, // Loop asleep.
  input wire logic oscEnable, // Oscillator enable.
  input wire logic multifunctionOut, // Pin level.
  input wire logic multifunctionOe // Pin drive enable.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  property p_bus_answer;
    s_req |=> s_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered by a single ack");
  property p_ack_cause;
    $rose(ack_o) |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_dat_hold;
    !ack_o |-> $stable(dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed outside an access");
  property p_reset_idle;
    $fell(reset) |-> multifunctionOe && !multifunctionOut;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pin not driven low after reset");
  property p_open_drain;
    multifunctionOut |-> multifunctionOe;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin high while not driven");
  property p_osc_off;
    &inputDebias |-> !oscEnable;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator on with both loops asleep");
  property p_if_asleep;
    inputDebias[0] [*2] |-> pumpHiz[0] && !pumpUp[0] && !pumpDown[0];
  endproperty
  a_if_asleep: assert property (p_if_asleep)
    else $error("sleeping IF loop still pumps");
  property p_rf_asleep;
    inputDebias[1] [*2] |-> pumpHiz[1] && !pumpUp[1] && !pumpDown[1];
  endproperty
  a_rf_asleep: assert property (p_rf_asleep)
    else $error("sleeping RF loop still pumps");
endmodule // dual_synth_mode_control_props
bind dual_synth_mode_control dual_synth_mode_control_props u_props (
  .ref_clk(ref_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .pumpUp(pumpUp), .pumpDown(pumpDown),
  .pumpHiz(pumpHiz), .inputDebias(inputDebias), .oscEnable(oscEnable),
  .multifunctionOut(multifunctionOut), .multifunctionOe(multifunctionOe)
);

// ---- tb/testbench.sv ----
// Self-checking bench for the dual synthesizer control block.
`timescale 1ns/1ps
module testbench;
  import dual_synth_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, linkClk, linkData, loadStrobe, oscEnable;
  logic multifunctionOut, multifunctionOe;
  logic [1:0] prescalerInput = 2'b00;
  logic [1:0] pumpUp, pumpDown, pumpHiz, pumpCurrentSelect, inputDebias;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int k;
  logic prevOut;
  always #50 ref_clk = ~ref_clk;
  // Both VCO inputs run at eight block clocks per cycle.
  always #400 prescalerInput = ~prescalerInput;
  serial_host_model u_host (.linkClk(linkClk), .linkData(linkData),
    .loadStrobe(loadStrobe));
  dual_synth_mode_control u_dual_synth_mode_control (.ref_clk(ref_clk),
    .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .linkClk(linkClk), .linkData(linkData), .loadStrobe(loadStrobe),
    .prescalerInput(prescalerInput), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .pumpHiz(pumpHiz), .pumpCurrentSelect(pumpCurrentSelect),
    .inputDebias(inputDebias), .oscEnable(oscEnable),
    .multifunctionOut(multifunctionOut), .multifunctionOe(multifunctionOe));
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge ref_clk);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 4'hf, 32'h0);
    check(rd, want);
  endtask
  // Modes are {monitor, lock, hiz, current, polarity}.
  function automatic logic [21:0] ref_word(input logic [14:0] r,
      input logic [4:0] modes, input logic [1:0] tgt);
    return {modes, r, tgt};
  endfunction
  function automatic logic [21:0] div_word(input logic [6:0] a,
      input logic [10:0] b, input logic m, input logic s,
      input logic [1:0] tgt);
    return {s, m, b, a, tgt};
  endfunction
  task automatic load(input logic [21:0] w);
    u_host.send(w);
    repeat (6) @(posedge ref_clk);
    rd_chk(8'h08 + {4'h0, w[1:0], 2'b00}, {12'h0, w[21:2]});
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(CTRL_OFFSET, {16'h0, CTRL_RESET});
    rd_chk(IF_REF_OFFSET, 32'h0);
    rd_chk(8'h40, 32'h0);
    check({oscEnable, multifunctionOe, multifunctionOut}, 3'b110);
    bus(1'b1, CTRL_OFFSET, 4'h2, 32'hffff_abcd);
    rd_chk(CTRL_OFFSET, 32'h0000_ab02);
    bus(1'b1, RF_DIV_OFFSET, 4'hf, 32'hffff_ffff);
    rd_chk(RF_DIV_OFFSET, 32'h0);
    done("registers");
    load(ref_word(15'd8, 5'b10011, 2'b00));
    load(ref_word(15'd5, 5'b10110, 2'b01));
    load(div_word(7'd3, 11'd3, 1'b1, 1'b0, 2'b11));
    load(div_word(7'd0, 11'd3, 1'b0, 1'b0, 2'b10));
    check(pumpCurrentSelect, 2'b11);
    check({pumpHiz[1], inputDebias[1]}, 2'b10);
    check({multifunctionOe, multifunctionOut}, 2'b10);
    load(ref_word(15'd5, 5'b10100, 2'b01));
    check(multifunctionOe, 1'b0);
    done("serial words and damping switch");
    load(ref_word(15'd8, 5'b11000, 2'b00));
    rd_chk(STATUS_OFFSET, 32'h0000_0140);
    check(pumpHiz, 2'b11);
    load(ref_word(15'd8, 5'b10000, 2'b00));
    load(ref_word(15'd5, 5'b00100, 2'b01));
    k = 0;
    prevOut = 1'b0;
    repeat (80) begin
      @(posedge ref_clk);
      #1;
      if (multifunctionOut === 1'b1 && prevOut !== 1'b1) begin
        k++;
      end
      prevOut = multifunctionOut;
    end
    check(k, 10);
    load(ref_word(15'd8, 5'b00000, 2'b00));
    repeat (3) @(posedge ref_clk);
    check({multifunctionOe, multifunctionOut}, 2'b10);
    done("multifunction pin");
    load(div_word(7'd3, 11'd3, 1'b1, 1'b1, 2'b11));
    rd_chk(STATUS_OFFSET, 32'h0000_0070);
    check({inputDebias, oscEnable}, 3'b101);
    load(div_word(7'd0, 11'd3, 1'b0, 1'b1, 2'b10));
    k = 0;
    do begin
      bus(1'b0, STATUS_OFFSET, 4'hf, 32'h0);
      k++;
    end while (rd[3:2] !== 2'b11 && k < 200);
    check(rd[3:2], 2'b11);
    check({inputDebias, oscEnable}, 3'b110);
    load(div_word(7'd0, 11'd3, 1'b0, 1'b0, 2'b10));
    check({inputDebias, oscEnable}, 3'b101);
    done("powerdown");
    results();
  end
endmodule // testbench
